/* File: design/ppr_lock.sv */
// Lock flag, unlock key sequence and one-way lock bookkeeping.
`timescale 1ns/10ps
module ppr_lock
    import ppr_pkg::*;
(
    // Clock and resets
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       soft_rst,
    // Bus events
    input  wire logic       wr_lock,
    input  wire logic       other_access,
    input  wire logic [7:0] wdata,
    // Configuration
    input  wire logic       one_way,
    // State
    output logic            locked,
    output logic            clr_used,
    output logic            set_used,
    output logic            armed
);

    ppr_seq_t state;
    ppr_seq_t next_state;
    logic     next_locked;
    logic     next_clr_used;
    logic     next_set_used;
    logic     set_ok;
    logic     clr_ok;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state    = state;
        next_locked   = locked;
        next_clr_used = clr_used;
        next_set_used = set_used;
        set_ok = !one_way || !set_used;
        clr_ok = !one_way || (!clr_used && !set_used);
        if (soft_rst) begin
            next_state    = SEQ_IDLE;
            next_locked   = 1'b0;
            next_clr_used = 1'b0;
            next_set_used = 1'b0;
        end else if (wr_lock) begin
            case (state)
                SEQ_IDLE: begin
                    next_state = (wdata == UNLOCK_KEY1) ? SEQ_HALF : SEQ_IDLE;
                end
                SEQ_HALF: begin
                    next_state = (wdata == UNLOCK_KEY2) ? SEQ_ARMED : SEQ_IDLE;
                end
                SEQ_ARMED: begin
                    next_state = SEQ_IDLE;
                    if (wdata[LOCK_BIT] && !locked && set_ok) begin
                        next_locked   = 1'b1;
                        next_set_used = 1'b1;
                    end else if (!wdata[LOCK_BIT] && locked && clr_ok) begin
                        next_locked   = 1'b0;
                        next_clr_used = 1'b1;
                    end
                end
                default: begin
                    next_state = SEQ_IDLE;
                end
            endcase
        end else if (other_access) begin
            next_state = SEQ_IDLE;
        end
        armed = (state == SEQ_ARMED);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state    <= SEQ_IDLE;
            locked   <= 1'b0;
            clr_used <= 1'b0;
            set_used <= 1'b0;
        end else begin
            state    <= next_state;
            locked   <= next_locked;
            clr_used <= next_clr_used;
            set_used <= next_set_used;
        end
    end

endmodule

/* File: design/ppr_mux.sv */
// Pin multiplexer: one pin picked per peripheral input by its code.
`timescale 1ns/10ps
module ppr_mux
    import ppr_pkg::*;
#(
    parameter int N = SEL_COUNT
) (
    // Pin levels and selector codes
    input  wire logic [31:0]        pins,
    input  wire logic [N*SEL_W-1:0] sel_flat,
    // Routed peripheral inputs
    output logic      [N-1:0]       routed
);

    // ****************************************************************
    // Selection
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < N; i++) begin
            routed[i] = ppr_pick(pins, sel_flat[i*SEL_W +: SEL_W]);
        end
    end

endmodule

/* File: design/ppr_pkg.sv */
// Constants, register map and helper functions of the pin routing block.
package ppr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int         SEL_COUNT   = 18;
    localparam int         SEL_W       = 5;
    localparam logic [7:0] SEL_BASE    = 8'h00;
    localparam logic [7:0] LOCK_ADDR   = 8'h20;
    localparam logic [7:0] STATUS_ADDR = 8'h21;
    localparam int         LOCK_BIT    = 0;

    // ****************************************************************
    // Unlock keys and selector defaults
    // ****************************************************************
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [SEL_W-1:0] SEL_RESET [0:SEL_COUNT-1] = '{
        5'h02, 5'h02, 5'h05, 5'h04, 5'h05, 5'h05, 5'h05, 5'h02, 5'h03,
        5'h05, 5'h01, 5'h00, 5'h05, 5'h01, 5'h02, 5'h03, 5'h01, 5'h00};

    // ****************************************************************
    // Two-wire capable pins, pin code is port * 8 + pin
    // ****************************************************************
    localparam int               SEL_SER_CLK = 13;
    localparam int               SEL_SER_DAT = 14;
    localparam logic [SEL_W-1:0] TW_PB1      = 5'h09;
    localparam logic [SEL_W-1:0] TW_PB2      = 5'h0a;
    localparam logic [SEL_W-1:0] TW_PC3      = 5'h13;
    localparam logic [SEL_W-1:0] TW_PC4      = 5'h14;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_HALF  = 3'b010,
        SEQ_ARMED = 3'b100
    } ppr_seq_t;

    function automatic logic ppr_pick(input logic [31:0] pins,
                                      input logic [SEL_W-1:0] code);
        return pins[code];
    endfunction

    function automatic logic ppr_two_wire_pin(input logic [SEL_W-1:0] c);
        return (c == TW_PB1) || (c == TW_PB2) ||
               (c == TW_PC3) || (c == TW_PC4);
    endfunction

endpackage

/* File: design/ppr_top.sv */
// Peripheral input pin routing with lockable selector registers.
//
// Overview of operation
// - Each 5-bit selector names the pin; power-on gives its listed default.
// - Two-wire thresholds apply only on port B 1, 2 and port C 3, 4.
// - While locked, writes to every selector are ignored.
// - Lock flag changes only on a reset or right after writes of 0x55 then 0xAA.
// - With one-way option, flag sets once per reset and keyed clears are refused.
// - With one-way option, a set flag stays set until next reset.
// - Sleep entry or exit never changes any selector.
// - Power-on reset restores defaults and removes any permanent lock.
// - Other resets leave every selector unchanged.
`timescale 1ns/10ps
module ppr_top
    import ppr_pkg::*;
(
    // Clock and power-on reset
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // Other device reset, sleep and configuration
    input  wire logic       DEV_RESET_N,
    input  wire logic       SLEEP,
    input  wire logic       ONE_SHOT_LOCK_OPTION,
    input  wire logic       TWO_WIRE_MODE,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // Pins
    input  wire logic [5:0] PORT_A_PIN,
    input  wire logic [7:0] PORT_B_PIN,
    input  wire logic [7:0] PORT_C_PIN,
    // Routed peripheral inputs
    output logic            IRQ_IN,
    output logic            TIMER0_CLOCK_IN,
    output logic            TIMER1_CLOCK_IN,
    output logic            TIMER1_GATE_IN,
    output logic            TIMER2_EXTERNAL_IN,
    output logic            CAPTURE_ONE_IN,
    output logic            CAPTURE_TWO_IN,
    output logic            WAVEFORM_GEN_IN,
    output logic            LOGIC_CELL_IN_A,
    output logic            LOGIC_CELL_IN_B,
    output logic            LOGIC_CELL_IN_C,
    output logic            LOGIC_CELL_IN_D,
    output logic            CONVERTER_TRIGGER_IN,
    output logic            SERIAL_CLOCK_IN,
    output logic            SERIAL_DATA_IN,
    output logic            SERIAL_SELECT_IN,
    output logic            UART_RECEIVE_IN,
    output logic            UART_SYNC_CLOCK_IN,
    // Lock state and two-wire buffer control
    output logic            SELECTION_LOCK_FLAG,
    output logic            SERIAL_CLOCK_TWO_WIRE_BUF,
    output logic            SERIAL_DATA_TWO_WIRE_BUF
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [21:0]          pin_meta;
    logic [21:0]          pin_sync;
    logic [3:0]           ctl_meta;
    logic [3:0]           ctl_sync;
    logic                 soft_rst;
    logic                 sleep_s;
    logic                 one_way_s;
    logic                 two_wire_s;
    logic [31:0]          pins;
    logic [SEL_W-1:0]     sel      [0:SEL_COUNT-1];
    logic [SEL_W-1:0]     next_sel [0:SEL_COUNT-1];
    logic [SEL_COUNT*SEL_W-1:0] sel_flat;
    logic [SEL_COUNT-1:0] routed;
    logic [SEL_COUNT-1:0] routed_q;
    logic [SEL_COUNT-1:0] next_routed_q;
    logic [7:0]           next_rdata;
    logic                 next_buf_clk;
    logic                 next_buf_dat;
    logic                 next_lock_out;
    logic                 hit_sel;
    logic                 hit_lock;
    logic                 hit_status;
    logic [4:0]           sel_idx;
    logic                 wr_lock;
    logic                 other_access;
    logic                 locked;
    logic                 clr_used;
    logic                 set_used;
    logic                 armed;

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    // Pins and control levels come from outside the clock domain, so
    // nothing reads them before the second flop.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pin_meta <= 22'h0;
            pin_sync <= 22'h0;
            ctl_meta <= 4'h1;
            ctl_sync <= 4'h1;
        end else begin
            pin_meta <= {PORT_C_PIN, PORT_B_PIN, PORT_A_PIN};
            pin_sync <= pin_meta;
            ctl_meta <= {TWO_WIRE_MODE, ONE_SHOT_LOCK_OPTION, SLEEP,
                         DEV_RESET_N};
            ctl_sync <= ctl_meta;
        end
    end

    always_comb begin
        soft_rst   = !ctl_sync[0];
        sleep_s    = ctl_sync[1];
        one_way_s  = ctl_sync[2];
        two_wire_s = ctl_sync[3];
        pins       = {8'h00, pin_sync[21:14], pin_sync[13:6],
                      2'b00, pin_sync[5:0]};
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    always_comb begin
        sel_idx      = ADDR[4:0];
        hit_sel      = (ADDR >= SEL_BASE) &&
                       (ADDR < SEL_BASE + 8'(SEL_COUNT));
        hit_lock     = (ADDR == LOCK_ADDR);
        hit_status   = (ADDR == STATUS_ADDR);
        wr_lock      = WR && hit_lock;
        // Any other access breaks the keys
        other_access = RD || (WR && !hit_lock);
    end

    // ****************************************************************
    // Lock control
    // ****************************************************************
    // Keyed flag change
    ppr_lock u_lock (
        .clk          (CLK),
        .rstn         (RSTN),
        .soft_rst     (soft_rst),
        .wr_lock      (wr_lock),
        .other_access (other_access),
        .wdata        (WDATA),
        .one_way      (one_way_s),
        .locked       (locked),
        .clr_used     (clr_used),
        .set_used     (set_used),
        .armed        (armed)
    );

    // ****************************************************************
    // Selector registers
    // ****************************************************************
    // Sleep and the non power-on reset do not appear here at all, so
    // the selections ride through both untouched.
    always_comb begin
        for (int i = 0; i < SEL_COUNT; i++) begin
            next_sel[i] = sel[i];
        end
        if (WR && hit_sel && !locked) begin
            next_sel[sel_idx - SEL_BASE[4:0]] = WDATA[SEL_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int i = 0; i < SEL_COUNT; i++) begin
                sel[i] <= SEL_RESET[i];
            end
        end else begin
            for (int i = 0; i < SEL_COUNT; i++) begin
                sel[i] <= next_sel[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < SEL_COUNT; i++) begin
            sel_flat[i*SEL_W +: SEL_W] = sel[i];
        end
    end

    // ****************************************************************
    // Pin multiplexer
    // ****************************************************************
    // Code picks the pin
    ppr_mux #(
        .N (SEL_COUNT)
    ) u_mux (
        .pins     (pins),
        .sel_flat (sel_flat),
        .routed   (routed)
    );

    // ****************************************************************
    // Output and read data
    // ****************************************************************
    always_comb begin
        next_routed_q = routed;
        next_lock_out = locked;
        // Two-wire buffer only on capable pins
        next_buf_clk  = two_wire_s && ppr_two_wire_pin(sel[SEL_SER_CLK]);
        next_buf_dat  = two_wire_s && ppr_two_wire_pin(sel[SEL_SER_DAT]);
        next_rdata    = 8'h00;
        // Read data stand for exactly one cycle after the strobe.
        if (RD) begin
            if (hit_sel) begin
                next_rdata = {3'b000, sel[sel_idx - SEL_BASE[4:0]]};
            end else if (hit_lock) begin
                next_rdata = {7'h00, locked};
            end else if (hit_status) begin
                next_rdata = {2'b00, armed, sleep_s, set_used, clr_used,
                              one_way_s, locked};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            routed_q                  <= '0;
            RDATA                     <= 8'h00;
            SELECTION_LOCK_FLAG       <= 1'b0;
            SERIAL_CLOCK_TWO_WIRE_BUF <= 1'b0;
            SERIAL_DATA_TWO_WIRE_BUF  <= 1'b0;
        end else begin
            routed_q                  <= next_routed_q;
            RDATA                     <= next_rdata;
            SELECTION_LOCK_FLAG       <= next_lock_out;
            SERIAL_CLOCK_TWO_WIRE_BUF <= next_buf_clk;
            SERIAL_DATA_TWO_WIRE_BUF  <= next_buf_dat;
        end
    end

    // ****************************************************************
    // Routed outputs
    // ****************************************************************
    // Each port is a bit of the routed register; the extra flop costs a
    // cycle of latency but keeps the outputs glitch free.
    always_comb begin
        IRQ_IN               = routed_q[0];
        TIMER0_CLOCK_IN      = routed_q[1];
        TIMER1_CLOCK_IN      = routed_q[2];
        TIMER1_GATE_IN       = routed_q[3];
        TIMER2_EXTERNAL_IN   = routed_q[4];
        CAPTURE_ONE_IN       = routed_q[5];
        CAPTURE_TWO_IN       = routed_q[6];
        WAVEFORM_GEN_IN      = routed_q[7];
        LOGIC_CELL_IN_A      = routed_q[8];
        LOGIC_CELL_IN_B      = routed_q[9];
        LOGIC_CELL_IN_C      = routed_q[10];
        LOGIC_CELL_IN_D      = routed_q[11];
        CONVERTER_TRIGGER_IN = routed_q[12];
        SERIAL_CLOCK_IN      = routed_q[13];
        SERIAL_DATA_IN       = routed_q[14];
        SERIAL_SELECT_IN     = routed_q[15];
        UART_RECEIVE_IN      = routed_q[16];
        UART_SYNC_CLOCK_IN   = routed_q[17];
    end

endmodule

/* File: tb/ppr_top_properties.sv */
// Port assertions of the pin routing block.
`timescale 1ns/10ps
module ppr_top_properties
    import ppr_pkg::*;
(
    // Clock and resets
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       DEV_RESET_N,
    // Configuration
    input wire logic       ONE_SHOT_LOCK_OPTION,
    input wire logic       TWO_WIRE_MODE,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // Lock and buffer state
    input wire logic       SELECTION_LOCK_FLAG,
    input wire logic       SERIAL_CLOCK_TWO_WIRE_BUF,
    input wire logic       SERIAL_DATA_TWO_WIRE_BUF
);
    // ****************************************************************
    // Clocking and sequences
    // ****************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // Six quiet cycles cover the lock port lag and the reset synchroniser.
    sequence s_quiet;
        (!WR && DEV_RESET_N) [*6];
    endsequence
    sequence s_one_way;
        (ONE_SHOT_LOCK_OPTION && DEV_RESET_N) [*6];
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_rdata_idle: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    a_code_width: assert property (
        RD && ADDR < 8'h12 |=> RDATA[7:5] == 3'h0)
        else $error("selector read wider than five bits");
    a_unmapped_zero: assert property (
        RD && ADDR > 8'h11 && ADDR != LOCK_ADDR && ADDR != STATUS_ADDR
        |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_flag_set_cause: assert property (
        $rose(SELECTION_LOCK_FLAG)
        |-> $past(WR && ADDR == LOCK_ADDR && WDATA[0], 2))
        else $error("lock flag set without a keyed write");
    a_flag_clr_cause: assert property (
        $fell(SELECTION_LOCK_FLAG)
        |-> $past(WR && ADDR == LOCK_ADDR && !WDATA[0], 2)
            || !$past(DEV_RESET_N, 3) || !$past(DEV_RESET_N, 4)
            || !$past(DEV_RESET_N, 5))
        else $error("lock flag cleared without cause");
    a_flag_quiet: assert property (
        s_quiet |=> $stable(SELECTION_LOCK_FLAG))
        else $error("lock flag moved with no write");
    a_one_way_hold: assert property (
        s_one_way ##0 SELECTION_LOCK_FLAG |=> SELECTION_LOCK_FLAG)
        else $error("one-way lock flag cleared");
    a_tw_mode_off: assert property (
        !TWO_WIRE_MODE [*3]
        |=> !SERIAL_CLOCK_TWO_WIRE_BUF && !SERIAL_DATA_TWO_WIRE_BUF)
        else $error("two-wire buffer on outside two-wire mode");
endmodule

bind ppr_top ppr_top_properties u_props (
    .CLK(CLK), .RSTN(RSTN), .DEV_RESET_N(DEV_RESET_N),
    .ONE_SHOT_LOCK_OPTION(ONE_SHOT_LOCK_OPTION),
    .TWO_WIRE_MODE(TWO_WIRE_MODE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SELECTION_LOCK_FLAG(SELECTION_LOCK_FLAG),
    .SERIAL_CLOCK_TWO_WIRE_BUF(SERIAL_CLOCK_TWO_WIRE_BUF),
    .SERIAL_DATA_TWO_WIRE_BUF(SERIAL_DATA_TWO_WIRE_BUF));

/* File: tb/ppr_top_test.sv */
// Self-checking testbench of the pin routing block.
`timescale 1ns/10ps
module ppr_top_test
    import ppr_pkg::*;
;
    logic        clk, rstn, dev_rst_n, sleep, one_way, two_wire;
    logic [7:0]  addr, wdata;
    logic        wr, rd;
    logic [5:0]  pa;
    logic [7:0]  pb, pc;
    wire  [7:0]  rdata;
    wire  [17:0] routed;
    wire         flag, ck_buf, dt_buf;
    int          error_cnt;
    int          comparisons;
    localparam logic [4:0] DEF [0:17] = '{5'h02, 5'h02, 5'h05, 5'h04,
        5'h05, 5'h05, 5'h05, 5'h02, 5'h03, 5'h05, 5'h01, 5'h00, 5'h05,
        5'h01, 5'h02, 5'h03, 5'h01, 5'h00};
    localparam logic [4:0] TW_CODE [0:5] = '{5'h09, 5'h0a, 5'h13, 5'h14,
        5'h0b, 5'h05};
    localparam logic [5:0] TW_EXP = 6'b001111;
    localparam logic [5:0] TW_PIN = 6'b001001;

    ppr_top uut (
        .CLK(clk), .RSTN(rstn), .DEV_RESET_N(dev_rst_n), .SLEEP(sleep),
        .ONE_SHOT_LOCK_OPTION(one_way), .TWO_WIRE_MODE(two_wire),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PORT_A_PIN(pa), .PORT_B_PIN(pb), .PORT_C_PIN(pc),
        .IRQ_IN(routed[0]), .TIMER0_CLOCK_IN(routed[1]),
        .TIMER1_CLOCK_IN(routed[2]), .TIMER1_GATE_IN(routed[3]),
        .TIMER2_EXTERNAL_IN(routed[4]), .CAPTURE_ONE_IN(routed[5]),
        .CAPTURE_TWO_IN(routed[6]), .WAVEFORM_GEN_IN(routed[7]),
        .LOGIC_CELL_IN_A(routed[8]), .LOGIC_CELL_IN_B(routed[9]),
        .LOGIC_CELL_IN_C(routed[10]), .LOGIC_CELL_IN_D(routed[11]),
        .CONVERTER_TRIGGER_IN(routed[12]), .SERIAL_CLOCK_IN(routed[13]),
        .SERIAL_DATA_IN(routed[14]), .SERIAL_SELECT_IN(routed[15]),
        .UART_RECEIVE_IN(routed[16]), .UART_SYNC_CLOCK_IN(routed[17]),
        .SELECTION_LOCK_FLAG(flag), .SERIAL_CLOCK_TWO_WIRE_BUF(ck_buf),
        .SERIAL_DATA_TWO_WIRE_BUF(dt_buf));

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask
    task automatic keyed(input logic [7:0] v);
        wr_reg(LOCK_ADDR, UNLOCK_KEY1);
        wr_reg(LOCK_ADDR, UNLOCK_KEY2);
        wr_reg(LOCK_ADDR, v);
    endtask
    task automatic chk_flag(input logic exp);
        addr <= LOCK_ADDR;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(flag, exp);
        chk(rdata, {7'h00, exp});
        @(posedge clk);
    endtask
    // Pins cross two synchroniser flops and an output register.
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic por();
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask
    task automatic dev_reset();
        dev_rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        dev_rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        logic [17:0] exp_r;
        for (int i = 0; i < 18; i++) begin
            chk_rd(8'(i), {3'h0, DEF[i]});
        end
        chk_rd(LOCK_ADDR, 8'h00);
        // Mixed pin levels catch an output wired to the wrong selector.
        pa <= 6'h15;
        settle();
        for (int i = 0; i < 18; i++) begin
            exp_r[i] = pa[DEF[i]];
        end
        chk(routed, exp_r);
        @(posedge clk);
    endtask
    task automatic t_route();
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 18; i++) begin
                wr_reg(8'(i), 8'(k));
            end
            pa <= 6'h01 << k;
            settle();
            chk(routed, 18'h3ffff);
            @(posedge clk);
            pa <= ~(6'h01 << k);
            settle();
            chk(routed, 18'h00000);
            @(posedge clk);
        end
    endtask
    task automatic t_lock();
        keyed(8'h01);
        chk_flag(1'b1);
        wr_reg(8'h00, 8'h11);
        chk_rd(8'h00, 8'h05);
        wr_reg(LOCK_ADDR, 8'h00);
        chk_flag(1'b1);
        for (int k = 0; k < 4; k++) begin
            wr_reg(LOCK_ADDR, UNLOCK_KEY1);
            case (k)
                0: chk_rd(8'h30, 8'h00);
                1: wr_reg(8'h30, 8'h00);
                2: wr_reg(LOCK_ADDR, 8'h54);
                default: wr_reg(8'h01, 8'h00);
            endcase
            wr_reg(LOCK_ADDR, UNLOCK_KEY2);
            wr_reg(LOCK_ADDR, 8'h00);
            chk_flag(1'b1);
        end
        keyed(8'h00);
        chk_flag(1'b0);
        wr_reg(8'h00, 8'h11);
        chk_rd(8'h00, 8'h11);
    endtask
    task automatic t_keep();
        sleep <= 1'b1;
        repeat (6) @(posedge clk);
        chk_rd(STATUS_ADDR, 8'h1c);
        sleep <= 1'b0;
        repeat (6) @(posedge clk);
        chk_rd(8'h00, 8'h11);
        chk_rd(8'h11, 8'h05);
        keyed(8'h01);
        dev_reset();
        chk_flag(1'b0);
        chk_rd(8'h00, 8'h11);
        chk_rd(8'h11, 8'h05);
    endtask
    task automatic t_one_way();
        one_way <= 1'b1;
        repeat (4) @(posedge clk);
        keyed(8'h01);
        chk_flag(1'b1);
        chk_rd(STATUS_ADDR, 8'h0b);
        keyed(8'h00);
        chk_flag(1'b1);
        wr_reg(8'h00, 8'h07);
        chk_rd(8'h00, 8'h11);
        dev_reset();
        chk_flag(1'b0);
        keyed(8'h01);
        chk_flag(1'b1);
        one_way <= 1'b0;
        por();
        chk_flag(1'b0);
        t_defaults();
    endtask
    task automatic t_two_wire();
        two_wire <= 1'b1;
        pb <= 8'h02;
        pc <= 8'h10;
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h0d, {3'h0, TW_CODE[k]});
            wr_reg(8'h0e, {3'h0, TW_CODE[k]});
            settle();
            chk({ck_buf, dt_buf}, {2{TW_EXP[k]}});
            chk(routed[14:13], {2{TW_PIN[k]}});
            @(posedge clk);
        end
        wr_reg(8'h0d, 8'h09);
        two_wire <= 1'b0;
        settle();
        chk(ck_buf, 1'b0);
    endtask

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        error_cnt = 0;
        comparisons = 0;
        {rstn, sleep, one_way, two_wire, wr, rd} = 6'h00;
        dev_rst_n = 1'b1;
        {addr, wdata, pb, pc} = 32'h0;
        pa = 6'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_route();
        t_lock();
        t_keep();
        t_one_way();
        t_two_wire();
        end_sim();
    end
endmodule
